// ===== verilog/spbc_pkg.sv
// Constants, types and register map of the system power and boot control block.
// Assumes a single 100 MHz always-on clock and software access over classic Wishbone.
//
// Functional notes
// R1: Cold reset input held low at least 1 ms causes a global reset.
// R2: Boot sequence follows the select level sampled at startup only.
// R3: Select low or floating: standard sequence, load from on-board flash only.
// R4: Select high: alternate sequence, SD card in 4-bit mode first, then flash.
// R5: Failed card load during alternate sequence falls back to on-board flash.
// R6: Select input has a pull-down; floating means standard, high means alternate.
// R7: Standby request is asserted whenever the device is in standby or off.
// R8: Power-on request is high to request power; it shows only the off mode.
// R9: Short button press while off moves the device to on.
// R10: Short button press while on raises a processor interrupt, no state change.
// R11: Button press longer than five seconds while on moves the device to off.
// R12: Write-protect input is active low; low protects configuration memory, permits flash protection.
// R13: Flash protection needs both the write-protect input and the software enable.
// R14: Button is synchronised, debounced and timed by a counter on the always-on clock.
package spbc_pkg;

  // ----------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------
  localparam int unsigned CLK_HZ         = 100_000_000;
  localparam int unsigned RST_MIN_US     = 1000;
  localparam int unsigned RST_MIN_CYC    = (RST_MIN_US * (CLK_HZ / 1_000_000));
  localparam int unsigned LONG_PRESS_MS  = 5000;
  localparam int unsigned LONG_PRESS_CYC = (LONG_PRESS_MS * (CLK_HZ / 1000));
  localparam int unsigned DEBOUNCE_MS    = 10;
  localparam int unsigned DEBOUNCE_CYC   = (DEBOUNCE_MS * (CLK_HZ / 1000));
  localparam int unsigned SYNC_ONLY_CYC  = 1;
  localparam int unsigned PIN_LAT_CYC    = 3;

  // ----------------------------------------------------------------
  // Register map (byte addresses) and fields
  // ----------------------------------------------------------------
  localparam logic [3:0] REG_CTRL_ADDR   = 4'h0;
  localparam logic [3:0] REG_STATUS_ADDR = 4'h4;
  localparam logic [3:0] REG_MASK_ADDR   = 4'h8;
  localparam logic [3:0] REG_STATE_ADDR  = 4'hC;
  localparam int CTRL_WP_EN_BIT = 0;
  localparam int CTRL_STBY_BIT  = 1;
  localparam int CTRL_W         = 2;
  localparam logic [CTRL_W-1:0] CTRL_RST = 2'h0;
  localparam int EVT_SHORT      = 0;
  localparam int EVT_LONG       = 1;
  localparam int EVT_CARD_FAIL  = 2;
  localparam int EVT_COLD       = 3;
  localparam int EVT_W          = 4;
  localparam logic [EVT_W-1:0] EVT_RST = 4'h0;
  localparam int STATE_PWR_LSB  = 0;
  localparam int STATE_ALT_BIT  = 3;
  localparam int STATE_BOOT_LSB = 4;
  localparam int STATE_FWP_BIT  = 9;
  localparam int STATE_EWP_BIT  = 10;
  localparam int STATE_W        = 11;

  // ----------------------------------------------------------------
  // State encodings
  // ----------------------------------------------------------------
  typedef enum logic [2:0] {
    PWR_OFF  = 3'b001,
    PWR_ON   = 3'b010,
    PWR_STBY = 3'b100
  } spbc_pwr_type;

  typedef enum logic [4:0] {
    BOOT_IDLE  = 5'b00001,
    BOOT_CARD  = 5'b00010,
    BOOT_FLASH = 5'b00100,
    BOOT_DONE  = 5'b01000,
    BOOT_FAIL  = 5'b10000
  } spbc_boot_type;

endpackage

// ===== verilog/spbc_reg_if.sv
// Interface between the control core and its Wishbone register file.
// Assumes both ends run on the same clock.
`timescale 1ns/1ps
interface spbc_reg_if;
  import spbc_pkg::*;
  logic [CTRL_W-1:0]  ctrl;
  logic               glob_rst;
  logic [EVT_W-1:0]   events;
  logic [STATE_W-1:0] state_word;
  logic               irq;
  modport regs (output ctrl, output irq, input glob_rst, input events, input state_word);
  modport core (input ctrl, input irq, output glob_rst, output events, output state_word);
endinterface

// ===== verilog/spbc_debounce.sv
// Two-flop synchroniser followed by a stability filter.
// Assumes the raw input is asynchronous to the clock.
`timescale 1ns/1ps
module spbc_debounce
  import spbc_pkg::*;
#(
  parameter int unsigned STABLE_CYC = SYNC_ONLY_CYC
) (
  input  wire logic ref_clk_in,
  input  wire logic sys_rst_in,
  input  wire logic raw_in,
  input  wire logic rst_level_in,
  output logic      stable_out
);

  logic        meta_reg;
  logic        sync_reg;
  logic [31:0] cnt_reg;

  // The first flop is read only by the second one.
  always_ff @(posedge ref_clk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      meta_reg <= 1'b0;
      sync_reg <= 1'b0;
    end else begin
      meta_reg <= raw_in;
      sync_reg <= meta_reg;
    end
  end

  // A new level is accepted only after it stood for the whole window.
  always_ff @(posedge ref_clk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      cnt_reg    <= 32'h0000_0000;
      stable_out <= 1'b0;
    end else if (sync_reg == stable_out) begin
      cnt_reg <= 32'h0000_0000;
    end else if (cnt_reg == 32'(STABLE_CYC - 1)) begin
      cnt_reg    <= 32'h0000_0000;
      stable_out <= sync_reg; // see R14
    end else begin
      cnt_reg <= cnt_reg + 32'h0000_0001;
    end
  end

  // The rst_level_in port is unused by the filter; it documents the idle level.
  debounce_window_a: assert property (@(posedge ref_clk_in) disable iff (sys_rst_in) // see R14
    $changed(stable_out) |-> $past(cnt_reg) == 32'(STABLE_CYC - 1))
    else $error("Filtered level changed before the stability window ended.");

endmodule

// ===== verilog/spbc_wb_regs.sv
// Classic Wishbone slave holding control, sticky status, mask and state readout.
// Assumes a single-cycle classic master that holds its request until ack.
`timescale 1ns/1ps
module spbc_wb_regs
  import spbc_pkg::*;
(
  input  wire logic        ref_clk_in,
  input  wire logic        sys_rst_in,
  input  wire logic        wb_cyc_in,
  input  wire logic        wb_stb_in,
  input  wire logic        wb_we_in,
  input  wire logic [3:0]  wb_adr_in,
  input  wire logic [3:0]  wb_sel_in,
  input  wire logic [31:0] wb_dat_in,
  output logic [31:0]      wb_dat_out,
  output logic             wb_ack_out,
  spbc_reg_if.regs         rif
);

  logic [EVT_W-1:0] status_reg;
  logic [EVT_W-1:0] mask_reg;
  logic             req;
  logic             wr_lane0;

  // Ack comes one cycle after the request and drops in the cycle after.
  assign req      = wb_cyc_in & wb_stb_in & ~wb_ack_out;
  assign wr_lane0 = req & wb_we_in & wb_sel_in[0];
  assign rif.irq  = |(status_reg & mask_reg);

  // ----------------------------------------------------------------
  // Bus answer
  // ----------------------------------------------------------------
  always_ff @(posedge ref_clk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      wb_ack_out <= 1'b0;
      wb_dat_out <= 32'h0000_0000;
    end else begin
      wb_ack_out <= req;
      if (req && !wb_we_in) begin
        case (wb_adr_in)
          REG_CTRL_ADDR:   wb_dat_out <= 32'(rif.ctrl);
          REG_STATUS_ADDR: wb_dat_out <= 32'(status_reg);
          REG_MASK_ADDR:   wb_dat_out <= 32'(mask_reg);
          REG_STATE_ADDR:  wb_dat_out <= 32'(rif.state_word);
          default:         wb_dat_out <= 32'h0000_0000;
        endcase
      end
    end
  end

  // Control and mask return to defaults on a cold reset as well.
  always_ff @(posedge ref_clk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      rif.ctrl <= CTRL_RST;
      mask_reg <= EVT_RST;
    end else if (rif.glob_rst) begin
      rif.ctrl <= CTRL_RST;
      mask_reg <= EVT_RST;
    end else if (wr_lane0) begin
      if (wb_adr_in == REG_CTRL_ADDR) begin
        rif.ctrl <= wb_dat_in[CTRL_W-1:0];
      end
      if (wb_adr_in == REG_MASK_ADDR) begin
        mask_reg <= wb_dat_in[EVT_W-1:0];
      end
    end
  end

  // Sticky status: write one to clear, a same-cycle event wins.
  always_ff @(posedge ref_clk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      status_reg <= EVT_RST;
    end else if (wr_lane0 && wb_adr_in == REG_STATUS_ADDR) begin
      status_reg <= (status_reg & ~wb_dat_in[EVT_W-1:0]) | rif.events;
    end else begin
      status_reg <= status_reg | rif.events;
    end
  end

endmodule

// ===== verilog/spbc_top.sv
// Power state, boot sequence, cold reset and write-protect control of the module.
// Assumes an always-on 100 MHz clock, carrier pins asynchronous, boot loader logic
// on the same clock, and software on classic Wishbone.
//
// Chosen here: register access over Wishbone and the register addresses.
`timescale 1ns/1ps
module spbc_top
  import spbc_pkg::*;
#(
  parameter int unsigned RST_MIN_CYCLES  = RST_MIN_CYC,
  parameter int unsigned LONG_CYCLES     = LONG_PRESS_CYC,
  parameter int unsigned DEBOUNCE_CYCLES = DEBOUNCE_CYC
) (
  input  wire logic        ref_clk_in,
  input  wire logic        sys_rst_in,
  input  wire logic        cold_reset_n_in,
  input  wire logic        boot_sequence_select_in,
  input  wire logic        power_button_in,
  input  wire logic        write_protect_n_in,
  input  wire logic        boot_ok_in,
  input  wire logic        boot_fail_in,
  input  wire logic        wb_cyc_in,
  input  wire logic        wb_stb_in,
  input  wire logic        wb_we_in,
  input  wire logic [3:0]  wb_adr_in,
  input  wire logic [3:0]  wb_sel_in,
  input  wire logic [31:0] wb_dat_in,
  output logic [31:0]      wb_dat_out,
  output logic             wb_ack_out,
  output logic             global_rst_out,
  output logic             standby_request_out,
  output logic             power_on_request_out,
  output logic             boot_card_req_out,
  output logic             boot_card_4bit_out,
  output logic             boot_flash_req_out,
  output logic             eeprom_wp_out,
  output logic             flash_wp_out,
  output logic             irq_out
);

  spbc_reg_if rif ();

  logic          cold_low_sync;
  logic          alt_sync;
  logic          button_stable;
  logic          wp_on_sync;
  logic [31:0]   low_cnt_reg;
  logic          glob_rst_reg;
  logic          strap_pending_reg;
  logic [1:0]    strap_wait_reg;
  logic          boot_sequence_select_reg;
  logic [31:0]   press_cnt_reg;
  logic          press_prev_reg;
  logic          long_done_reg;
  logic          short_press;
  logic          long_press;
  spbc_pwr_type  pwr_state_reg;
  spbc_boot_type boot_state_reg;
  logic [EVT_W-1:0] events_next;

  // ----------------------------------------------------------------
  // Pin synchronisers and button filter
  // ----------------------------------------------------------------
  // Levels idle low after reset; the cold reset pin is inverted so its idle is low too.
  spbc_debounce #(.STABLE_CYC(SYNC_ONLY_CYC)) u_sync_cold (
    .ref_clk_in   (ref_clk_in),
    .sys_rst_in   (sys_rst_in),
    .raw_in       (~cold_reset_n_in),
    .rst_level_in (1'b0),
    .stable_out   (cold_low_sync)
  );

  // Floating select reads low thanks to the pad pull-down, giving the standard sequence.
  spbc_debounce #(.STABLE_CYC(SYNC_ONLY_CYC)) u_sync_alt ( // see R6
    .ref_clk_in   (ref_clk_in),
    .sys_rst_in   (sys_rst_in),
    .raw_in       (boot_sequence_select_in),
    .rst_level_in (1'b0),
    .stable_out   (alt_sync)
  );

  // Contact bounce is filtered so one press never counts twice.
  spbc_debounce #(.STABLE_CYC(DEBOUNCE_CYCLES)) u_deb_button ( // see R14
    .ref_clk_in   (ref_clk_in),
    .sys_rst_in   (sys_rst_in),
    .raw_in       (power_button_in),
    .rst_level_in (1'b0),
    .stable_out   (button_stable)
  );

  // Inverted so an idle pull-up reads as not protecting.
  spbc_debounce #(.STABLE_CYC(SYNC_ONLY_CYC)) u_sync_wp (
    .ref_clk_in   (ref_clk_in),
    .sys_rst_in   (sys_rst_in),
    .raw_in       (~write_protect_n_in),
    .rst_level_in (1'b0),
    .stable_out   (wp_on_sync)
  );

  // ----------------------------------------------------------------
  // Cold reset qualification
  // ----------------------------------------------------------------
  // Only a low level that lasts the full minimum time resets; glitches are ignored.
  // Here cold_low_sync is high while the pin is low.
  always_ff @(posedge ref_clk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      low_cnt_reg  <= 32'h0000_0000;
      glob_rst_reg <= 1'b0;
    end else if (!cold_low_sync) begin
      low_cnt_reg  <= 32'h0000_0000;
      glob_rst_reg <= 1'b0;
    end else if (low_cnt_reg == 32'(RST_MIN_CYCLES - 1)) begin
      glob_rst_reg <= 1'b1; // see R1
    end else begin
      low_cnt_reg <= low_cnt_reg + 32'h0000_0001;
    end
  end

  assign global_rst_out = glob_rst_reg;
  assign rif.glob_rst   = glob_rst_reg;

  // ----------------------------------------------------------------
  // Boot strap capture
  // ----------------------------------------------------------------
  // The strap is taken once, after the synchroniser has refilled following any reset.
  // Without the wait a power-on reset would read the zero the synchroniser was held at.
  always_ff @(posedge ref_clk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      strap_pending_reg <= 1'b1;
      strap_wait_reg    <= 2'h0;
      boot_sequence_select_reg      <= 1'b0;
    end else if (glob_rst_reg) begin
      strap_pending_reg <= 1'b1;
      strap_wait_reg    <= 2'h0;
    end else if (strap_wait_reg != 2'(PIN_LAT_CYC)) begin
      strap_wait_reg <= strap_wait_reg + 2'h1;
    end else if (strap_pending_reg) begin
      strap_pending_reg <= 1'b0;
      boot_sequence_select_reg      <= alt_sync; // see R2
    end
  end

  // ----------------------------------------------------------------
  // Button press timing
  // ----------------------------------------------------------------
  // A long press acts while still held; its release is then not a short press.
  always_ff @(posedge ref_clk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      press_cnt_reg  <= 32'h0000_0000;
      press_prev_reg <= 1'b0;
      long_done_reg  <= 1'b0;
    end else begin
      press_prev_reg <= button_stable;
      if (!button_stable) begin
        press_cnt_reg <= 32'h0000_0000;
        long_done_reg <= 1'b0;
      end else if (long_press) begin
        long_done_reg <= 1'b1;
      end else if (!long_done_reg) begin
        press_cnt_reg <= press_cnt_reg + 32'h0000_0001; // see R14
      end
    end
  end

  assign long_press  = button_stable & ~long_done_reg & (press_cnt_reg == 32'(LONG_CYCLES)); // see R11
  assign short_press = press_prev_reg & ~button_stable & ~long_done_reg;

  // ----------------------------------------------------------------
  // Power state
  // ----------------------------------------------------------------
  // Standby is entered and left under software control from the on state.
  always_ff @(posedge ref_clk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      pwr_state_reg <= PWR_ON;
    end else if (glob_rst_reg) begin
      pwr_state_reg <= PWR_ON;
    end else begin
      case (pwr_state_reg)
        PWR_OFF: begin
          if (short_press) begin
            pwr_state_reg <= PWR_ON; // see R9
          end
        end
        PWR_ON: begin
          if (long_press) begin
            pwr_state_reg <= PWR_OFF; // see R11
          end else if (rif.ctrl[CTRL_STBY_BIT]) begin
            pwr_state_reg <= PWR_STBY;
          end
        end
        PWR_STBY: begin
          if (long_press) begin
            pwr_state_reg <= PWR_OFF;
          end else if (!rif.ctrl[CTRL_STBY_BIT]) begin
            pwr_state_reg <= PWR_ON;
          end
        end
        default: pwr_state_reg <= PWR_OFF;
      endcase
    end
  end

  // Standby voltage is requested in standby and off; power-on drops only when off.
  assign standby_request_out  = (pwr_state_reg != PWR_ON);  // see R7
  assign power_on_request_out = (pwr_state_reg != PWR_OFF); // see R8

  // ----------------------------------------------------------------
  // Boot sequence
  // ----------------------------------------------------------------
  // The sequence restarts on each power-up, always with the strap from the last reset.
  always_ff @(posedge ref_clk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      boot_state_reg <= BOOT_IDLE;
    end else if (glob_rst_reg || pwr_state_reg == PWR_OFF) begin
      boot_state_reg <= BOOT_IDLE;
    end else begin
      case (boot_state_reg)
        BOOT_IDLE: begin
          if (!strap_pending_reg && pwr_state_reg == PWR_ON) begin
            boot_state_reg <= boot_sequence_select_reg ? BOOT_CARD : BOOT_FLASH; // see R3 R4
          end
        end
        BOOT_CARD: begin
          if (boot_ok_in) begin
            boot_state_reg <= BOOT_DONE;
          end else if (boot_fail_in) begin
            boot_state_reg <= BOOT_FLASH; // see R5
          end
        end
        BOOT_FLASH: begin
          if (boot_ok_in) begin
            boot_state_reg <= BOOT_DONE;
          end else if (boot_fail_in) begin
            boot_state_reg <= BOOT_FAIL;
          end
        end
        BOOT_DONE: boot_state_reg <= BOOT_DONE;
        BOOT_FAIL: boot_state_reg <= BOOT_FAIL;
        default:   boot_state_reg <= BOOT_IDLE;
      endcase
    end
  end

  // The card is only ever driven as a 4-bit bus during its attempt.
  assign boot_card_req_out  = (boot_state_reg == BOOT_CARD);
  assign boot_card_4bit_out = (boot_state_reg == BOOT_CARD); // see R4
  assign boot_flash_req_out = (boot_state_reg == BOOT_FLASH);

  // ----------------------------------------------------------------
  // Write protection
  // ----------------------------------------------------------------
  // The pin alone protects the configuration memory, never the flash.
  assign eeprom_wp_out = wp_on_sync;                               // see R12
  assign flash_wp_out  = wp_on_sync & rif.ctrl[CTRL_WP_EN_BIT];    // see R13

  // ----------------------------------------------------------------
  // Events, state readout and interrupt
  // ----------------------------------------------------------------
  always_comb begin
    events_next                = EVT_RST;
    events_next[EVT_SHORT]     = short_press & (pwr_state_reg != PWR_OFF); // see R10
    events_next[EVT_LONG]      = long_press & (pwr_state_reg != PWR_OFF);
    events_next[EVT_CARD_FAIL] = (boot_state_reg == BOOT_CARD) & boot_fail_in & ~boot_ok_in;
    events_next[EVT_COLD]      = glob_rst_reg & ~strap_pending_reg;
  end

  assign rif.events     = events_next;
  assign rif.state_word = {eeprom_wp_out, flash_wp_out, boot_state_reg, boot_sequence_select_reg, pwr_state_reg};
  assign irq_out        = rif.irq;

  spbc_wb_regs u_regs (
    .ref_clk_in (ref_clk_in),
    .sys_rst_in (sys_rst_in),
    .wb_cyc_in  (wb_cyc_in),
    .wb_stb_in  (wb_stb_in),
    .wb_we_in   (wb_we_in),
    .wb_adr_in  (wb_adr_in),
    .wb_sel_in  (wb_sel_in),
    .wb_dat_in  (wb_dat_in),
    .wb_dat_out (wb_dat_out),
    .wb_ack_out (wb_ack_out),
    .rif        (rif)
  );

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  cold_rst_time_a: assert property (@(posedge ref_clk_in) disable iff (sys_rst_in) // see R1
    $rose(glob_rst_reg) |-> $past(low_cnt_reg) == 32'(RST_MIN_CYCLES - 1) && $past(cold_low_sync))
    else $error("Global reset rose without a full-length low pulse.");

  strap_hold_a: assert property (@(posedge ref_clk_in) disable iff (sys_rst_in) // see R2
    !strap_pending_reg && $past(!strap_pending_reg) |-> $stable(boot_sequence_select_reg))
    else $error("Boot strap changed after it was captured.");

  std_boot_a: assert property (@(posedge ref_clk_in) disable iff (sys_rst_in) // see R3
    $rose(boot_flash_req_out) && $past(boot_state_reg) == BOOT_IDLE |-> !boot_sequence_select_reg)
    else $error("Standard sequence started with the alternate strap.");

  boot_sequence_select_a: assert property (@(posedge ref_clk_in) disable iff (sys_rst_in) // see R4
    boot_card_req_out |-> boot_sequence_select_reg && boot_card_4bit_out)
    else $error("Card boot attempted without the alternate strap.");

  card_fallback_a: assert property (@(posedge ref_clk_in) disable iff (sys_rst_in) // see R5
    boot_card_req_out && boot_fail_in && !boot_ok_in && !glob_rst_reg && pwr_state_reg != PWR_OFF
    |=> boot_flash_req_out && rif.events == EVT_RST)
    else $error("Failed card load did not fall back to flash.");

  stby_req_a: assert property (@(posedge ref_clk_in) disable iff (sys_rst_in) // see R7
    $fell(rif.ctrl[CTRL_STBY_BIT]) && pwr_state_reg == PWR_STBY && !long_press && !glob_rst_reg
    |=> !standby_request_out && power_on_request_out)
    else $error("Leaving standby did not drop the standby request.");

  off_state_a: assert property (@(posedge ref_clk_in) disable iff (sys_rst_in) // see R8
    $fell(power_on_request_out) |-> $past(long_press) && standby_request_out)
    else $error("Power-on request fell without a long press.");

  wake_short_a: assert property (@(posedge ref_clk_in) disable iff (sys_rst_in) // see R9
    short_press && pwr_state_reg == PWR_OFF && !glob_rst_reg |=> pwr_state_reg == PWR_ON ##1 !short_press)
    else $error("Short press while off did not power up.");

  irq_short_a: assert property (@(posedge ref_clk_in) disable iff (sys_rst_in) // see R10
    short_press && pwr_state_reg == PWR_ON && !rif.ctrl[CTRL_STBY_BIT] && !glob_rst_reg
    |-> rif.events[EVT_SHORT] ##1 pwr_state_reg == PWR_ON)
    else $error("Short press while on did not interrupt or changed state.");

  long_off_a: assert property (@(posedge ref_clk_in) disable iff (sys_rst_in) // see R11
    $rose(long_press) && pwr_state_reg == PWR_ON && !glob_rst_reg
    |-> $past(press_cnt_reg) == 32'(LONG_CYCLES - 1) ##1 pwr_state_reg == PWR_OFF)
    else $error("Long press did not switch the device off at the exact count.");

  eeprom_wp_a: assert property (@(posedge ref_clk_in) disable iff (sys_rst_in) // see R12
    $changed(eeprom_wp_out) |-> eeprom_wp_out == !$past(write_protect_n_in, PIN_LAT_CYC))
    else $error("Configuration memory protection does not follow the pin.");

  flash_wp_a: assert property (@(posedge ref_clk_in) disable iff (sys_rst_in) // see R13
    flash_wp_out |-> eeprom_wp_out && rif.ctrl[CTRL_WP_EN_BIT])
    else $error("Flash protected without both pin and software enable.");

endmodule

// ===== tb/spbc_carrier.sv
// Carrier model: the boot loader that answers the block's load requests.
// Assumes the block's always-on clock; a card load always fails here.
`timescale 1ns/1ps
module spbc_carrier (
  input  wire logic clk_in,
  input  wire logic card_req_in,
  input  wire logic flash_req_in,
  output logic      ok_out = 1'b0,
  output logic      fail_out = 1'b0
);
  // One-cycle answers, so that the fallback from card to flash is always exercised.
  always @(posedge clk_in) begin
    fail_out <= card_req_in & ~fail_out;
    ok_out   <= flash_req_in & ~ok_out;
  end
endmodule

// ===== tb/tb_top.sv
// Self-checking bench of the power and boot control block.
// Assumes the carrier model answers loads; pins and Wishbone are driven here.
`timescale 1ns/1ps
module tb_top;
  import spbc_pkg::*;
  logic ref_clk_in = 1'b0, sys_rst_in = 1'b1, cold_n = 1'b1, cyc = 1'b0, we = 1'b0, btn = 1'b0;
  logic strap = 1'b1, wp_n = 1'b1, ack, grst, stby, pon, creq, freq, fwp, irq, ok, fail, c4, ewp;
  logic saw4 = 1'b0;
  logic [3:0] adr = 4'h0;
  logic [31:0] dat = 32'h0, q, rdat;
  int miscompares = 0, n_tests = 0;
  always #5 ref_clk_in = ~ref_clk_in;
  // Remembers whether a card attempt ever ran with the four-bit bus mode.
  always @(posedge ref_clk_in) if (creq && c4) saw4 <= 1'b1;
  spbc_carrier car_u (.clk_in(ref_clk_in), .card_req_in(creq), .flash_req_in(freq), .ok_out(ok), .fail_out(fail));
  spbc_top #(.RST_MIN_CYCLES(8), .LONG_CYCLES(50), .DEBOUNCE_CYCLES(4)) dut_u (.ref_clk_in(ref_clk_in),
    .sys_rst_in(sys_rst_in), .cold_reset_n_in(cold_n), .boot_sequence_select_in(strap), .power_button_in(btn),
    .write_protect_n_in(wp_n), .boot_ok_in(ok), .boot_fail_in(fail), .wb_cyc_in(cyc), .wb_stb_in(cyc),
    .wb_we_in(we), .wb_adr_in(adr), .wb_sel_in(4'hF), .wb_dat_in(dat), .wb_dat_out(rdat), .wb_ack_out(ack),
    .global_rst_out(grst), .standby_request_out(stby), .power_on_request_out(pon), .boot_card_req_out(creq),
    .boot_card_4bit_out(c4), .boot_flash_req_out(freq), .eeprom_wp_out(ewp), .flash_wp_out(fwp), .irq_out(irq));
  task chk(input string n, input logic [31:0] e, input logic [31:0] s);
    n_tests++;
    if (s !== e) $display("mismatch %s expected %h seen %h", n, e, s);
    if (s !== e) miscompares++;
  endtask
  task end_sim;
    if (miscompares == 0 && n_tests > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  task wb(input logic w, input logic [3:0] a, input logic [31:0] d = 32'h0);
    @(posedge ref_clk_in);
    {cyc, we, adr, dat} <= {1'b1, w, a, d};
    for (int i = 0; i < 20 && ack !== 1'b1; i++) @(posedge ref_clk_in);
    q = rdat;
    {cyc, we} <= 2'b00;
    chk("ack", 32'h1, ack);
    if (ack !== 1'b1) end_sim();
  endtask
  task press(input int n);
    btn <= 1'b1;
    repeat (n) @(posedge ref_clk_in);
    btn <= 1'b0;
    // The release must outlast the filter before the next press may start.
    repeat (12) @(posedge ref_clk_in);
  endtask
  task off_on;
    press(80);
    chk("stby_off", 32'h1, stby);
    chk("pon_off", 32'h0, pon);
    press(15);
    repeat (40) @(posedge ref_clk_in);
    wb(1'b0, REG_STATE_ADDR);
    chk("state_boot", 32'h8A, q);
    chk("card_4bit", 32'h1, saw4);
  endtask
  task sw_ctrl;
    wb(1'b1, REG_STATUS_ADDR, 32'hF);
    wb(1'b1, REG_MASK_ADDR, 32'h1);
    press(15);
    repeat (15) @(posedge ref_clk_in);
    chk("irq", 32'h1, irq);
    chk("pon_irq", 32'h1, pon);
    wb(1'b1, REG_STATUS_ADDR, 32'h1);
    wp_n <= 1'b0;
    wb(1'b1, REG_CTRL_ADDR, 32'h2);
    repeat (4) @(posedge ref_clk_in);
    chk("irq_clr", 32'h0, irq);
    chk("stby", 32'h1, stby);
    chk("pon_stby", 32'h1, pon);
    chk("fwp", 32'h0, fwp);
    chk("ewp", 32'h1, ewp);
    wb(1'b1, REG_CTRL_ADDR, 32'h1);
    wb(1'b0, REG_STATE_ADDR);
    chk("state_wp", 32'h68A, q);
    wb(1'b0, 4'h2);
    chk("unmapped", 32'h0, q);
  endtask
  task cold;
    cold_n <= 1'b0;
    repeat (20) @(posedge ref_clk_in);
    chk("grst", 32'h1, grst);
    cold_n <= 1'b1;
    repeat (8) @(posedge ref_clk_in);
    wb(1'b0, REG_STATUS_ADDR);
    chk("status_cold", 32'h8, q);
  endtask
  initial begin
    repeat (8) @(posedge ref_clk_in);
    sys_rst_in <= 1'b0;
    repeat (6) @(posedge ref_clk_in);
    strap <= 1'b0;
    off_on();
    sw_ctrl();
    cold();
    end_sim();
  end
endmodule
